// ==== sgd_checker.sv ====
// Purpose: port-level checks for sgd_step_diag
// Assumes: bound to the top module, sees only its ports
// Notes: latches are internal, so checks key on sense input runs
`timescale 1ns/1ps
`default_nettype none
module sgd_checker
   import sgd_pkg::*;
#(
   parameter int PERIOD_W = sgd_pkg::PERIOD_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire sgd_pkg::sgd_wb_req_s wb_req,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire sgd_pkg::sgd_sense_s sense_in,
   input wire logic bridge_enable,
   input wire logic step_dir,
   input wire logic [sgd_pkg::POS_W-1:0] coil_position,
   input wire logic diag_out,
   input wire logic irq
);
   import sgd_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // a new request, a long hot spell, then a warm spell
   sequence s_req;
      wb_req.cyc && wb_req.stb && !wb_ack_o;
   endsequence
   sequence s_hot;
      sense_in.ot [*4];
   endsequence
   sequence s_warm;
      (sense_in.otpw && !sense_in.ot) [*4];
   endsequence
   chk_ack_one_cycle: assert property (s_req |=> wb_ack_o)
      else $error("ack not one cycle after request");
   chk_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_unmapped_zero: assert property (s_req ##0 (!wb_req.we && wb_req.adr == 8'h20)
      |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_hot_bridge_off: assert property (s_hot |-> ##1 !bridge_enable)
      else $error("bridge on while hot");
   chk_warm_still_off: assert property (s_hot ##1 s_warm |-> !bridge_enable)
      else $error("bridge back on above warning level");
   // past reset excluded: reset itself moves the count to zero
   chk_pos_up_wrap: assert property (($changed(coil_position) && !step_dir && $stable(step_dir)
      && !$past(reset)) |-> coil_position == $past(coil_position) + 10'd1)
      else $error("upward step not plus one");
   chk_pos_down_step: assert property (($changed(coil_position) && step_dir && $stable(step_dir)
      && !$past(reset)) |-> coil_position == $past(coil_position) - 10'd1)
      else $error("downward step not minus one");
   chk_off_no_step: assert property ((!bridge_enable [*3] ##0 !$past(reset))
      |-> $stable(coil_position))
      else $error("position moved with bridges off");
endmodule // sgd_checker
bind sgd_step_diag sgd_checker #(.PERIOD_W(PERIOD_W)) sgd_checker_i (.clk, .reset, .wb_req,
   .wb_dat_o, .wb_ack_o, .sense_in, .bridge_enable, .step_dir, .coil_position, .diag_out, .irq);
`default_nettype wire

// ==== sgd_host.sv ====
// Purpose: host model, classic Wishbone master for the register file
// Assumes: tasks are entered right after a rising edge
// Notes: waits on ack without limit; the bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
module sgd_host (
   input wire logic clk,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   output var sgd_pkg::sgd_wb_req_s wb_req
);
   import sgd_pkg::*;
   initial wb_req = '0;
   // hold the whole request until ack is seen, then release for a cycle
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: wd};
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_req <= '0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] dummy;
      xfer(1'b1, a, wd, dummy);
   endtask
   task automatic ramp(input logic [23:0] target, input logic [23:0] inc);
      logic [23:0] v;
      v = inc;
      while (v < target) begin
         wr(ADR_VELOCITY, {8'h00, v});
         repeat (8) @(posedge clk);
         v = v + inc;
      end
      wr(ADR_VELOCITY, {8'h00, target});
   endtask
   task automatic restart(input logic [31:0] cfg);
      wr(ADR_GLOBAL_CONFIG, cfg & 32'hFFFF_FFFE);
      wr(ADR_GLOBAL_CONFIG, cfg);
   endtask
endmodule // sgd_host
`default_nettype wire

// ==== sgd_pkg.sv ====
// Purpose: constants and carriers for the step generator and driver diagnostics
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: all offsets, fields, reset values and counts live here
// Contract
// - new velocity applies at once, no ramp
// - signed velocity, rate = v*fclk/2^24
// - step period in clocks per microstep
// - step selection toggles diag per microstep
// - position counter wraps 1023 to 0
// - prewarning and shutdown temperature flags
// - shutdown holds until below prewarning level
// - short accepted after three retries
// - confirmed short: bridges off, coil flag set
// - short restart only by disable then enable
// - open load when coil current unreachable
// - open load flags cause no action
// - fault role: diag when driver abnormal
// - index role: diag at position zero
// - diag functions chosen by config bits
// - velocity math uses internal clock
package sgd_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADR_GLOBAL_CONFIG = 8'h00;
   localparam logic [7:0] ADR_VELOCITY = 8'h04;
   localparam logic [7:0] ADR_STEP_PERIOD = 8'h08;
   localparam logic [7:0] ADR_SPEED_THRS = 8'h0C;
   localparam logic [7:0] ADR_POSITION = 8'h10;
   localparam logic [7:0] ADR_DRIVER_STATUS = 8'h14;
   localparam logic [7:0] ADR_INT_STATUS = 8'h18;
   localparam logic [7:0] ADR_INT_MASK = 8'h1C;
   // ****************************************
   // field positions
   // ****************************************
   localparam int GC_ENABLE = 0;
   localparam int GC_DIAG_FAULT = 1;
   localparam int GC_DIAG_INDEX = 2;
   localparam int GC_DIAG_STEP = 3;
   localparam int GC_W = 4;
   localparam logic [3:0] GC_RESET = 4'h2;
   localparam int DS_W = 11;
   localparam int INT_OTPW = 0;
   localparam int INT_OT = 1;
   localparam int INT_SHORT = 2;
   localparam int INT_OLA = 3;
   localparam int INT_OLB = 4;
   localparam int INT_W = 5;
   // ****************************************
   // sizes and counts
   // ****************************************
   localparam int VEL_W = 24;
   localparam int ACC_W = 24;
   localparam int POS_W = 10;
   localparam int PERIOD_W = 20;
   localparam int SHORT_RETRIES = 3;
   localparam int CLK_HZ = 40_000_000;
   localparam logic [19:0] THRS_RESET = 20'h0_0000;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } sgd_wb_req_s;
   typedef struct packed {
      logic olb;
      logic ola;
      logic short_supply_coil_b;
      logic short_supply_coil_a;
      logic short_ground_coil_b;
      logic short_ground_coil_a;
      logic ot;
      logic otpw;
   } sgd_sense_s;
endpackage

// ==== sgd_short_filter.sv ====
// Purpose: retry filter and latch for one short-circuit comparator
// Assumes: det already synchronised to clk
// Notes: cleared only while the driver is disabled
`timescale 1ns/1ps
`default_nettype none
module sgd_short_filter #(
   parameter int RETRIES = 3
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic det,
   input wire logic rearm,
   output logic tripped
);
   import sgd_pkg::*;
   logic det_d_r;
   logic [2:0] hits_r;
   logic tripped_r;
   logic det_rise;

   // detection events are edges, so one long short counts once per retry
   assign det_rise = det & ~det_d_r;
   assign tripped = tripped_r;

   // edge history
   always_ff @(posedge clk) begin
      if (reset) begin
         det_d_r <= 1'b0;
      end else begin
         det_d_r <= det;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || rearm) begin
         hits_r <= 3'h0;
      end else if (det_rise && hits_r <= 3'(RETRIES)) begin
         hits_r <= hits_r + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || rearm) begin
         tripped_r <= 1'b0;
      end else if (det_rise && hits_r == 3'(RETRIES)) begin
         tripped_r <= 1'b1;
      end
   end
endmodule // sgd_short_filter
`default_nettype wire

// ==== sgd_step_diag.sv ====
// Purpose: internal step generator, diag pin and protection flags
// Assumes: sense inputs come from analog comparators, asynchronous
// Notes: registers over classic Wishbone, one level interrupt
`timescale 1ns/1ps
`default_nettype none
module sgd_step_diag #(
   parameter int PERIOD_W = sgd_pkg::PERIOD_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire sgd_pkg::sgd_wb_req_s wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire sgd_pkg::sgd_sense_s sense_in,
   output logic bridge_enable,
   output logic step_dir,
   output logic [sgd_pkg::POS_W-1:0] coil_position,
   output logic diag_out,
   output logic irq
);
   import sgd_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic [GC_W-1:0] global_config_r;
   logic [VEL_W-1:0] vel_r;
   logic [PERIOD_W-1:0] thrs_r;
   logic [INT_W-1:0] int_st_r;
   logic [INT_W-1:0] int_mask_r;
   logic [7:0] sense_s1_r;
   logic [7:0] sense_s2_r;
   sgd_sense_s sense;
   logic ot_latch_r;
   logic [3:0] short_trip;
   logic short_any;
   logic bridge_on;
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W:0] acc_sum;
   logic [VEL_W-1:0] vel_mag;
   logic step_pulse;
   logic [POS_W-1:0] pos_r;
   logic [PERIOD_W-1:0] cnt_r;
   logic [PERIOD_W-1:0] period_r;
   logic step_tgl_r;
   logic diag_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic wr_en;
   logic rd_en;
   logic [31:0] rd_mux;
   logic [DS_W-1:0] driver_status;
   logic [INT_W-1:0] ev_now;
   logic [INT_W-1:0] ev_prev_r;
   logic [INT_W-1:0] ev_set;
   logic fast;
   logic standstill;

   // byte-lane merge for writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ****************************************
   // input synchronisers
   // ****************************************
   // comparators are asynchronous to clk: two flops before use
   // each bit is an independent level, so no multi-bit word crosses here
   always_ff @(posedge clk) begin
      if (reset) begin
         sense_s1_r <= 8'h00;
         sense_s2_r <= 8'h00;
      end else begin
         sense_s1_r <= sense_in;
         sense_s2_r <= sense_s1_r;
      end
   end
   assign sense = sgd_sense_s'(sense_s2_r);

   // ****************************************
   // wishbone slave
   // ****************************************
   // ack one cycle after the request, then drop, so back to back works
   // writes land on the edge that raises ack, while the request still stands
   // reads are captured on that same edge, so data stands together with ack
   assign wr_en = wb_req.cyc & wb_req.stb & wb_req.we & ~ack_r;
   assign rd_en = wb_req.cyc & wb_req.stb & ~wb_req.we & ~ack_r;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // handshake
   always_ff @(posedge clk) begin
      if (reset) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_req.cyc & wb_req.stb & ~ack_r;
      end
   end

   // velocity reads back as written, sign in its top bit, not extended
   // read mux, unmapped reads zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (wb_req.adr)
         ADR_GLOBAL_CONFIG: rd_mux[GC_W-1:0] = global_config_r;
         ADR_VELOCITY: rd_mux[VEL_W-1:0] = vel_r;
         ADR_STEP_PERIOD: rd_mux[PERIOD_W-1:0] = period_r;
         ADR_SPEED_THRS: rd_mux[PERIOD_W-1:0] = thrs_r;
         ADR_POSITION: rd_mux[POS_W-1:0] = pos_r;
         ADR_DRIVER_STATUS: rd_mux[DS_W-1:0] = driver_status;
         ADR_INT_STATUS: rd_mux[INT_W-1:0] = int_st_r;
         ADR_INT_MASK: rd_mux[INT_W-1:0] = int_mask_r;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data captured with the ack
   always_ff @(posedge clk) begin
      if (reset) begin
         rdat_r <= 32'h0000_0000;
      end else if (rd_en) begin
         rdat_r <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         global_config_r <= GC_RESET;
      end else if (wr_en && wb_req.adr == ADR_GLOBAL_CONFIG) begin
         global_config_r <= GC_W'(lane_merge(32'(global_config_r), wb_req.dat, wb_req.sel));
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         vel_r <= '0;
      end else if (wr_en && wb_req.adr == ADR_VELOCITY) begin
         vel_r <= VEL_W'(lane_merge(32'(vel_r), wb_req.dat, wb_req.sel));
      end
   end

   // speed threshold, compared against the measured period
   always_ff @(posedge clk) begin
      if (reset) begin
         thrs_r <= PERIOD_W'(THRS_RESET);
      end else if (wr_en && wb_req.adr == ADR_SPEED_THRS) begin
         thrs_r <= PERIOD_W'(lane_merge(32'(thrs_r), wb_req.dat, wb_req.sel));
      end
   end

   // interrupt mask
   always_ff @(posedge clk) begin
      if (reset) begin
         int_mask_r <= '0;
      end else if (wr_en && wb_req.adr == ADR_INT_MASK) begin
         int_mask_r <= INT_W'(lane_merge(32'(int_mask_r), wb_req.dat, wb_req.sel));
      end
   end

   // ****************************************
   // thermal protection
   // ****************************************
   // ot wins over the clear, so a hot die never re-enables for a cycle
   // trade-off: no cool-down timer, the warning comparator sets the floor
   // hold off until below prewarning
   always_ff @(posedge clk) begin
      if (reset) begin
         ot_latch_r <= 1'b0;
      end else if (sense.ot) begin
         ot_latch_r <= 1'b1;
      end else if (!sense.otpw) begin
         ot_latch_r <= 1'b0;
      end
   end

   // ****************************************
   // short protection
   // ****************************************
   // rearm is the inverted enable bit, so a disable/enable pair restarts
   // one retry filter per comparator
   sgd_short_filter #(.RETRIES(SHORT_RETRIES)) u_short_ground_coil_a (
      .clk(clk),
      .reset(reset),
      .det(sense.short_ground_coil_a),
      .rearm(~global_config_r[GC_ENABLE]),
      .tripped(short_trip[0])
   );
   sgd_short_filter #(.RETRIES(SHORT_RETRIES)) u_short_ground_coil_b (
      .clk(clk),
      .reset(reset),
      .det(sense.short_ground_coil_b),
      .rearm(~global_config_r[GC_ENABLE]),
      .tripped(short_trip[1])
   );
   sgd_short_filter #(.RETRIES(SHORT_RETRIES)) u_short_supply_coil_a (
      .clk(clk),
      .reset(reset),
      .det(sense.short_supply_coil_a),
      .rearm(~global_config_r[GC_ENABLE]),
      .tripped(short_trip[2])
   );
   sgd_short_filter #(.RETRIES(SHORT_RETRIES)) u_short_supply_coil_b (
      .clk(clk),
      .reset(reset),
      .det(sense.short_supply_coil_b),
      .rearm(~global_config_r[GC_ENABLE]),
      .tripped(short_trip[3])
   );
   assign short_any = |short_trip;

   // open load deliberately left out here
   assign bridge_on = global_config_r[GC_ENABLE] & ~ot_latch_r & ~short_any;
   assign bridge_enable = bridge_on;

   // ****************************************
   // step generator
   // ****************************************
   // limitation: at most one microstep every two clocks, bounded by the signed 24-bit width
   // accumulator freezes with the bridges, so a restart keeps its phase
   // magnitude of the signed velocity
   assign vel_mag = vel_r[VEL_W-1] ? (~vel_r + VEL_W'(1)) : vel_r;
   assign acc_sum = {1'b0, acc_r} + {1'b0, vel_mag};
   // carry out of 2^24 gives a microstep
   assign step_pulse = bridge_on & acc_sum[ACC_W];
   assign step_dir = vel_r[VEL_W-1];

   // phase accumulator on the core clock
   always_ff @(posedge clk) begin
      if (reset) begin
         acc_r <= '0;
      end else if (bridge_on) begin
         acc_r <= acc_sum[ACC_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pos_r <= '0;
      end else if (step_pulse) begin
         pos_r <= step_dir ? pos_r - POS_W'(1) : pos_r + POS_W'(1);
      end
   end
   assign coil_position = pos_r;

   // measured between executed steps, so it shows the real rate
   // clocks between microsteps
   // counter saturates, so a stalled drive reads full scale
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_r <= '0;
         period_r <= '1;
      end else if (step_pulse) begin
         period_r <= cnt_r + PERIOD_W'(1);
         cnt_r <= '0;
      end else if (cnt_r != '1) begin
         cnt_r <= cnt_r + PERIOD_W'(1);
      end else begin
         period_r <= '1;
      end
   end

   assign standstill = (period_r == '1);
   assign fast = ~standstill & (period_r <= thrs_r);

   // ****************************************
   // diagnostic output
   // ****************************************
   // toggle per executed microstep
   always_ff @(posedge clk) begin
      if (reset) begin
         step_tgl_r <= 1'b0;
      end else if (step_pulse) begin
         step_tgl_r <= ~step_tgl_r;
      end
   end

   // registered so the pin never glitches while roles are switched
   // ored enabled roles
   always_ff @(posedge clk) begin
      if (reset) begin
         diag_r <= 1'b0;
      end else begin
         diag_r <= (global_config_r[GC_DIAG_FAULT] & (ot_latch_r | short_any))
                 | (global_config_r[GC_DIAG_INDEX] & (pos_r == '0))
                 | (global_config_r[GC_DIAG_STEP] & step_tgl_r);
      end
   end
   assign diag_out = diag_r;

   // ****************************************
   // status word
   // ****************************************
   // warning and open load are live, shutdown and shorts are latched
   // temperature flags: warning live, shutdown latched
   assign driver_status = {bridge_on, standstill, fast, sense.olb, sense.ola,
                        short_trip[3], short_trip[2], short_trip[1],
                        short_trip[0], ot_latch_r, sense.otpw};

   // ****************************************
   // interrupts
   // ****************************************
   // events are rising edges, so a long fault sets its bit only once
   assign ev_now = {sense.olb, sense.ola, short_any, ot_latch_r, sense.otpw};
   assign ev_set = ev_now & ~ev_prev_r;

   // rising-edge history
   always_ff @(posedge clk) begin
      if (reset) begin
         ev_prev_r <= '0;
      end else begin
         ev_prev_r <= ev_now;
      end
   end

   // sticky, write one to clear, set wins
   // a clear needs byte lane 0, since every bit sits in the low byte
   always_ff @(posedge clk) begin
      if (reset) begin
         int_st_r <= '0;
      end else if (wr_en && wb_req.adr == ADR_INT_STATUS && wb_req.sel[0]) begin
         int_st_r <= (int_st_r & ~wb_req.dat[INT_W-1:0]) | ev_set;
      end else begin
         int_st_r <= int_st_r | ev_set;
      end
   end
   assign irq = |(int_st_r & int_mask_r);
endmodule // sgd_step_diag
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench for sgd_step_diag
// Assumes: PERIOD_W cut to 8 so the step period saturates at 0xFF
// Notes: sense inputs are driven as clean levels
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sgd_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   sgd_wb_req_s wb_req;
   logic [31:0] wb_dat_o, rdat;
   logic wb_ack_o, bridge_enable, step_dir, diag_out, irq;
   sgd_sense_s sense_in = '0;
   logic [POS_W-1:0] coil_position, pos_q = '0, p, d;
   logic diag_q = 1'b0;
   int err_total = 0;
   int comparisons = 0;
   int steps = 0;
   int toggles = 0;
   // 40 MHz
   always #12.5 clk = ~clk;
   sgd_step_diag #(.PERIOD_W(8)) sgd_step_diag_i (.clk, .reset, .wb_req, .wb_dat_o,
      .wb_ack_o, .sense_in, .bridge_enable, .step_dir, .coil_position, .diag_out, .irq);
   sgd_host sgd_host_i (.clk, .wb_dat_o, .wb_ack_o, .wb_req);
   // count moves and diag edges, pre-edge values on both sides
   always @(posedge clk) begin
      if (coil_position !== pos_q) steps++;
      if (diag_out !== diag_q) toggles++;
      pos_q <= coil_position;
      diag_q <= diag_out;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      sgd_host_i.wr(a, wd);
   endtask
   task automatic rd(input logic [7:0] a);
      sgd_host_i.xfer(1'b0, a, 32'h0000_0000, rdat);
   endtask
   task automatic t_regs;
      rd(ADR_GLOBAL_CONFIG); chk(rdat, 32'h0000_0002);
      rd(ADR_STEP_PERIOD); chk(rdat, 32'h0000_00FF);
      wr(ADR_POSITION, 32'h0000_0155);
      rd(ADR_POSITION); chk(rdat, 32'h0000_0000);
      rd(ADR_DRIVER_STATUS);
      chk(rdat & 32'h0000_0300, 32'h0000_0200);
      rd(8'h20); chk(rdat, 32'h0000_0000);
      chk({bridge_enable, irq}, 32'h0000_0000);
      $display("t_regs done");
   endtask
   task automatic t_index;
      wr(ADR_GLOBAL_CONFIG, 32'h0000_0004);
      tick(3); chk(diag_out, 32'h0000_0001);
      wr(ADR_VELOCITY, 32'h0040_0000);
      wr(ADR_GLOBAL_CONFIG, 32'h0000_0005);
      tick(10);
      wr(ADR_GLOBAL_CONFIG, 32'h0000_0004);
      tick(3); chk(diag_out, 32'h0000_0000);
      $display("t_index done");
   endtask
   task automatic t_step;
      wr(ADR_VELOCITY, 32'h0000_0000);
      wr(ADR_GLOBAL_CONFIG, 32'h0000_0009);
      tick(3);
      steps = 0;
      toggles = 0;
      sgd_host_i.ramp(24'h40_0000, 24'h10_0000);
      p = coil_position;
      tick(64);
      d = coil_position - p; chk(d, 32'h0000_0010);
      rd(ADR_STEP_PERIOD); chk(rdat, 32'h0000_0004);
      wr(ADR_SPEED_THRS, 32'h0000_0004);
      rd(ADR_SPEED_THRS);
      chk(rdat, 32'h0000_0004);
      rd(ADR_DRIVER_STATUS);
      chk(rdat & 32'h0000_0300, 32'h0000_0100);
      wr(ADR_SPEED_THRS, 32'h0000_0003);
      rd(ADR_DRIVER_STATUS);
      chk(rdat & 32'h0000_0300, 32'h0000_0000);
      for (int i = 0; i < 5000 && coil_position != 10'h3FF; i++) tick(1);
      while (coil_position == 10'h3FF) tick(1);
      chk(coil_position, 32'h0000_0000);
      wr(ADR_VELOCITY, 32'h00C0_0000);
      p = coil_position;
      tick(64);
      d = p - coil_position; chk(d, 32'h0000_0010);
      chk(step_dir, 32'h0000_0001);
      wr(ADR_GLOBAL_CONFIG, 32'h0000_0008);
      tick(4); chk(toggles, steps);
      $display("t_step done");
   endtask
   task automatic t_temp;
      wr(ADR_VELOCITY, 32'h0000_0000);
      wr(ADR_GLOBAL_CONFIG, 32'h0000_0003);
      wr(ADR_INT_MASK, 32'h0000_0000);
      sense_in <= 8'h01;
      tick(5); chk(irq, 32'h0000_0000);
      rd(ADR_INT_STATUS); chk(rdat & 32'h0000_0001, 32'h0000_0001);
      wr(ADR_INT_MASK, 32'h0000_001F); chk(irq, 32'h0000_0001);
      rd(ADR_DRIVER_STATUS); chk(rdat & 32'h0000_0403, 32'h0000_0401);
      sense_in <= 8'h03;
      tick(5); chk(bridge_enable, 32'h0000_0000);
      chk(diag_out, 32'h0000_0001);
      sense_in <= 8'h01;
      tick(6); chk(bridge_enable, 32'h0000_0000);
      sense_in <= 8'h00;
      tick(6); chk(bridge_enable, 32'h0000_0001);
      chk(diag_out, 32'h0000_0000);
      wr(ADR_INT_STATUS, 32'h0000_001F); chk(irq, 32'h0000_0000);
      $display("t_temp done");
   endtask
   task automatic pulse(input int k);
      sense_in[k] <= 1'b1;
      tick(4);
      sense_in[k] <= 1'b0;
      tick(4);
   endtask
   task automatic t_short;
      for (int k = 2; k < 6; k++) begin
         sgd_host_i.restart(32'h0000_0003);
         repeat (3) pulse(k);
         chk(bridge_enable, 32'h0000_0001);
         pulse(k); chk(bridge_enable, 32'h0000_0000);
         chk(diag_out, 32'h0000_0001);
         rd(ADR_DRIVER_STATUS); chk(rdat[k], 32'h0000_0001);
         tick(20); chk(bridge_enable, 32'h0000_0000);
      end
      sgd_host_i.restart(32'h0000_0003); chk(bridge_enable, 32'h0000_0001);
      rd(ADR_DRIVER_STATUS); chk(rdat & 32'h0000_003C, 32'h0000_0000);
      $display("t_short done");
   endtask
   task automatic t_open;
      // flags read while turning at moderate speed
      wr(ADR_VELOCITY, 32'h0010_0000);
      sense_in <= 8'hC0;
      tick(5);
      rd(ADR_DRIVER_STATUS); chk(rdat & 32'h0000_04C0, 32'h0000_04C0);
      chk({bridge_enable, diag_out}, 32'h0000_0002);
      rd(ADR_INT_STATUS);
      chk(rdat & 32'h0000_001C, 32'h0000_001C);
      chk(irq, 32'h0000_0001);
      sense_in <= 8'h00;
      $display("t_open done");
   endtask
   task automatic test_done;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // main sequence, reset held three cycles
   initial begin
      tick(3);
      reset <= 1'b0;
      tick(1);
      t_regs;
      t_index;
      t_step;
      t_temp;
      t_short;
      t_open;
      test_done;
   end
   // watchdog, several times the expected run of about 4600 cycles
   initial begin
      tick(40000);
      err_total++;
      test_done;
   end
endmodule // tb_top
`default_nettype wire
